// ===== core/srsc_rx_csr_map.vh
// bit positions, reset values and sizes of the receive control/status word
`ifndef SRSC_RX_CSR_MAP_VH
`define SRSC_RX_CSR_MAP_VH

`define SRSC_W_BITS        16
`define SRSC_B_BUF_SET     2
`define SRSC_B_HALF_DUPLEX 3
`define SRSC_B_CHAR_MATCH_IRQ_ENABLE     4
`define SRSC_B_DONE_IE     5
`define SRSC_B_DONE_SEC    6
`define SRSC_B_DONE_PRI    7
`define SRSC_F_ADDR_LO     8
`define SRSC_F_ADDR_HI     11
`define SRSC_B_RX_ACTIVE   12
`define SRSC_B_CHAR_FLAG   15
`define SRSC_ADDR_BITS     4
`define SRSC_CHAR_CNT      16
`define SRSC_BYTE_BITS     8
`define SRSC_PTR_CHAR_TBL  4'h8
`define SRSC_SYNC_BASIC    4'h8
`define SRSC_ZERO_W        16'h0000
`define SRSC_ZERO_ADDR     4'h0
`define SRSC_ZERO_BYTE     8'h00

`endif

// ===== core/srsc_char_table.v
// sixteen recognisable character patterns with registered read and parallel match
`timescale 1ns/1ps
`default_nettype none
`include "srsc_rx_csr_map.vh"

module srsc_char_table #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             mclk,       // interface clock
   input  wire             wr_en,      // pattern write strobe
   input  wire [AW-1:0]    addr,       // pattern address for read and write
   input  wire [WIDTH-1:0] wr_data,    // pattern write data
   output reg  [WIDTH-1:0] rd_data,    // registered pattern read data
   input  wire [WIDTH-1:0] cand,       // character under test
   input  wire             cand_wide,  // candidate wider than a byte or doubled
   output reg              hit,        // some pattern matches
   output reg  [AW-1:0]    hit_addr    // lowest matching address
);

   reg [WIDTH-1:0] pat [0:DEPTH-1];
   integer i;

   // narrow characters meet the upper-byte pattern only
   function match;
      input [WIDTH-1:0] p;
      input [WIDTH-1:0] c;
      input             wide;
      begin
         if (wide)
            match = (p == c);
         else
            match = (p[WIDTH-1:`SRSC_BYTE_BITS] == c[`SRSC_BYTE_BITS-1:0]);
      end
   endfunction

   always @(posedge mclk)
   begin
      if (wr_en)
         pat[addr] <= wr_data;
      rd_data <= pat[addr];
   end

   always @*
   begin
      hit      = 1'b0;
      hit_addr = {AW{1'b0}};
      for (i = DEPTH - 1; i >= 0; i = i - 1)
         if (match(pat[i], cand, cand_wide))
         begin
            hit      = 1'b1;
            hit_addr = i[AW-1:0];
         end
   end

endmodule // srsc_char_table
`default_nettype wire

// ===== core/srsc_rx_csr.v
// receive control and status word of the synchronous line interface
// How it works
// - buffer-set bit read-only, cleared by reset; zero means primary pair
// - half-duplex bit inhibits receiver while transmit active; read/write, reset clears
// - character interrupt enable lets the character flag request the receive vector
// - in double-character mode a flagged character reaches memory one character later
// - done enable requests the receive vector while either done flag is set
// - done flags set on own count overflow or by recognition sequence control
// - both done flags are software read/write and cleared by reset
// - four-bit field latches address of the character that set the flag
// - total transparency suppresses all character recognition
// - basic unit, field bits 8 to 10 flag preset control characters 0 to 2
// - field bit 11 follows sync detection, which can set the character flag
// - narrow characters match upper byte only; wider ones use both bytes
// - with recognition, field holds binary address, stable one character time
// - field writable only while neither transmit nor receive active
// - receive active set after one or two consecutive sync characters
// - early end of transfer leaves buffer-set bit unchanged
// - character flag sets on every detection; interrupt only when enabled
`timescale 1ns/1ps
`default_nettype none
`include "srsc_rx_csr_map.vh"

module srsc_rx_csr #(
   parameter       RECOG_OPT  = 1,        // recognition option fitted
   parameter       SYNC_COUNT = 2,        // sync characters needed, 1 or 2
   parameter       ACT_ON_DATA = 0,       // active on first non-sync character
   parameter [15:0] CTRL_CHAR0 = 16'h0000, // basic unit preset control character 0
   parameter [15:0] CTRL_CHAR1 = 16'h0000, // basic unit preset control character 1
   parameter [15:0] CTRL_CHAR2 = 16'h0000  // basic unit preset control character 2
) (
   input  wire        mclk,         // interface clock, 20 MHz
   input  wire        sys_rst,      // initialize, synchronous active high
   input  wire        master_clear, // master clear pulse
   input  wire        csr_wr,       // write strobe for the status word
   input  wire [1:0]  csr_be,       // byte enables, bit 1 upper byte
   input  wire [15:0] csr_wdata,    // write data
   output reg  [15:0] csr_rdata,    // read data of the status word
   input  wire [3:0]  regerr_ptr,   // register/error pointer field
   input  wire        total_transp, // total transparency mode
   input  wire        win_wr,       // indirect window write strobe
   input  wire [15:0] win_wdata,    // indirect window write data
   output wire [15:0] win_rdata,    // indirect window read data
   input  wire        rx_go,        // receive go
   input  wire        rx_term,      // transfer-ending flag
   input  wire        tx_active,    // transmitter active
   input  wire        cc_ovf_pri,   // primary count overflow pulse
   input  wire        cc_ovf_sec,   // secondary count overflow pulse
   input  wire        seq_done_pri, // sequence control sets primary done
   input  wire        seq_done_sec, // sequence control sets secondary done
   input  wire        rx_char_stb,  // assembled character pulse
   input  wire [15:0] rx_char,      // assembled character
   input  wire        rx_char_wide, // wide or double character
   input  wire        rx_double,    // double-character transfer
   input  wire        sync_det,     // sync character seen on this strobe
   input  wire        sync_flag_en, // sync detection raises the character flag
   input  wire        sync_lost,    // forces resynchronisation
   output wire        rx_enable,    // receiver not inhibited
   output reg         mem_xfer_stb, // character may go to memory
   output reg         rx_irq        // receive vector request
);

   ////////////////////////////////////////////////////////////////////////////
   reg        buf_set;
   reg        half_duplex;
   reg        char_match_irq_enable;
   reg        done_ie;
   reg        done_pri;
   reg        done_sec;
   reg  [3:0] char_addr;
   reg        char_flag;
   reg        rx_active;
   reg        xfer_hold;
   reg  [5:0] sync_st;
   reg  [5:0] next_sync_st;

   localparam [5:0] ST_HUNT = 6'b000001;
   localparam [5:0] ST_ONE  = 6'b000010;
   localparam [5:0] ST_TWO  = 6'b000100;

   wire clr       = sys_rst | master_clear;
   wire wr_lo     = csr_wr & csr_be[0];
   wire wr_hi     = csr_wr & csr_be[1];
   wire char_in   = rx_char_stb & rx_enable;
   wire recog_on  = char_in & ~total_transp;
   wire tbl_hit;
   wire [3:0] tbl_addr;
   wire addr_wr_ok = (RECOG_OPT != 0) & ~tx_active & ~rx_active;
   wire tbl_sel   = (regerr_ptr == `SRSC_PTR_CHAR_TBL);

   assign rx_enable = rx_go & ~(half_duplex & tx_active);

   srsc_char_table #(
      .WIDTH (`SRSC_W_BITS),
      .DEPTH (`SRSC_CHAR_CNT),
      .AW    (`SRSC_ADDR_BITS)
   ) u_tbl (
      .mclk      (mclk),
      .wr_en     (win_wr & tbl_sel),
      .addr      (char_addr),
      .wr_data   (win_wdata),
      .rd_data   (win_rdata),
      .cand      (rx_char),
      .cand_wide (rx_char_wide),
      .hit       (tbl_hit),
      .hit_addr  (tbl_addr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // basic unit compare against preset switches
   function sw_match;
      input [15:0] p;
      input [15:0] c;
      input        wide;
      begin
         if (wide)
            sw_match = (p == c);
         else
            sw_match = (p[`SRSC_W_BITS-1:`SRSC_BYTE_BITS] == c[`SRSC_BYTE_BITS-1:0]);
      end
   endfunction

   wire [2:0] basic_hit = {sw_match(CTRL_CHAR2, rx_char, rx_char_wide),
                           sw_match(CTRL_CHAR1, rx_char, rx_char_wide),
                           sw_match(CTRL_CHAR0, rx_char, rx_char_wide)};
   wire sync_hit  = sync_det & sync_flag_en;
   wire det_recog = recog_on & (tbl_hit | sync_hit);
   wire det_basic = recog_on & ((|basic_hit) | sync_hit);
   wire detect    = (RECOG_OPT != 0) ? det_recog : det_basic;
   wire [3:0] det_addr = (RECOG_OPT != 0) ?
                         (tbl_hit ? tbl_addr : `SRSC_SYNC_BASIC) :
                         {sync_hit, basic_hit};

   ////////////////////////////////////////////////////////////////////////////
   // control bits and buffer set
   always @(posedge mclk)
   begin
      if (clr)
      begin
         buf_set     <= 1'b0;
         half_duplex <= 1'b0;
         char_match_irq_enable     <= 1'b0;
         done_ie     <= 1'b0;
      end
      else
      begin
         // only a full count flips the set; go drop or end flag leaves it
         if ((cc_ovf_pri & ~buf_set) | (cc_ovf_sec & buf_set))
            buf_set <= ~buf_set;
         if (wr_lo)
         begin
            half_duplex <= csr_wdata[`SRSC_B_HALF_DUPLEX];
            char_match_irq_enable     <= csr_wdata[`SRSC_B_CHAR_MATCH_IRQ_ENABLE];
            done_ie     <= csr_wdata[`SRSC_B_DONE_IE];
         end
      end
   end

   // done flags: hardware set wins over a software clear
   always @(posedge mclk)
   begin
      if (clr)
      begin
         done_pri <= 1'b0;
         done_sec <= 1'b0;
      end
      else
      begin
         if (cc_ovf_pri | seq_done_pri)
            done_pri <= 1'b1;
         else if (wr_lo)
            done_pri <= csr_wdata[`SRSC_B_DONE_PRI];
         if (cc_ovf_sec | seq_done_sec)
            done_sec <= 1'b1;
         else if (wr_lo)
            done_sec <= csr_wdata[`SRSC_B_DONE_SEC];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // character flag and address latch
   always @(posedge mclk)
   begin
      if (clr)
      begin
         char_addr <= `SRSC_ZERO_ADDR;
         char_flag <= 1'b0;
      end
      else
      begin
         if (detect)
            char_flag <= 1'b1;
         else if (wr_hi & ~csr_wdata[`SRSC_B_CHAR_FLAG])
            char_flag <= 1'b0;
         // captures only on strobes, so an address stands a full character time
         if (detect)
            char_addr <= det_addr;
         else if (wr_hi & addr_wr_ok)
            char_addr <= csr_wdata[`SRSC_F_ADDR_HI:`SRSC_F_ADDR_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sync hunt and receive active
   always @*
   begin
      next_sync_st = sync_st;
      case (sync_st)
         ST_HUNT:
            if (char_in & sync_det)
               next_sync_st = (SYNC_COUNT == 1) ? ST_TWO : ST_ONE;
         ST_ONE:
            if (char_in)
               next_sync_st = sync_det ? ST_TWO : ST_HUNT;
         ST_TWO:
            next_sync_st = ST_TWO;
         default:
            next_sync_st = ST_HUNT;
      endcase
      if (~rx_go | sync_lost)
         next_sync_st = ST_HUNT;
   end

   always @(posedge mclk)
   begin
      if (clr)
      begin
         sync_st   <= ST_HUNT;
         rx_active <= 1'b0;
      end
      else
      begin
         sync_st <= next_sync_st;
         if (~rx_go | sync_lost)
            rx_active <= 1'b0;
         else if (sync_st == ST_TWO &&
                  (ACT_ON_DATA == 0 || (char_in && !sync_det)))
            rx_active <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory strobe and interrupt request
   always @(posedge mclk)
   begin
      if (clr)
      begin
         xfer_hold    <= 1'b0;
         mem_xfer_stb <= 1'b0;
         rx_irq       <= 1'b0;
      end
      else
      begin
         // the interrupting pair goes out with the next character
         xfer_hold    <= char_in ? (detect & rx_double) : xfer_hold;
         mem_xfer_stb <= char_in & (xfer_hold | ~(detect & rx_double));
         rx_irq       <= (char_flag & char_match_irq_enable) |
                         (done_ie & (done_pri | done_sec));
      end
   end

   always @*
   begin
      csr_rdata = `SRSC_ZERO_W;
      csr_rdata[`SRSC_B_BUF_SET]     = buf_set;
      csr_rdata[`SRSC_B_HALF_DUPLEX] = half_duplex;
      csr_rdata[`SRSC_B_CHAR_MATCH_IRQ_ENABLE]     = char_match_irq_enable;
      csr_rdata[`SRSC_B_DONE_IE]     = done_ie;
      csr_rdata[`SRSC_B_DONE_SEC]    = done_sec;
      csr_rdata[`SRSC_B_DONE_PRI]    = done_pri;
      csr_rdata[`SRSC_F_ADDR_HI:`SRSC_F_ADDR_LO] = char_addr;
      csr_rdata[`SRSC_B_RX_ACTIVE]   = rx_active;
      csr_rdata[`SRSC_B_CHAR_FLAG]   = char_flag;
   end

endmodule // srsc_rx_csr
`default_nettype wire

// ===== dv/srsc_rx_csr_sva.sv
// checker for the receive control and status word
`timescale 1ns/1ps
`default_nettype none
module srsc_rx_csr_sva (
   input wire logic        mclk,         // interface clock
   input wire logic        sys_rst,      // initialize
   input wire logic        master_clear, // master clear
   input wire logic        csr_wr,       // write strobe
   input wire logic [1:0]  csr_be,       // byte enables
   input wire logic [15:0] csr_wdata,    // write data
   input wire logic [15:0] csr_rdata,    // status word
   input wire logic        total_transp, // total transparency
   input wire logic        rx_go,        // receive go
   input wire logic        tx_active,    // transmitter active
   input wire logic        cc_ovf_pri,   // primary overflow
   input wire logic        cc_ovf_sec,   // secondary overflow
   input wire logic        seq_done_sec, // sequence sets secondary done
   input wire logic        rx_char_stb,  // character strobe
   input wire logic        rx_enable,    // receiver enabled
   input wire logic        rx_irq        // receive request
);
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (sys_rst || master_clear);

   AST_RXEN:
      assert property (rx_enable == (rx_go && !(csr_rdata[3] && tx_active)))
      else $error("receiver enable wrong");
   AST_CLEAR:
      assert property ($fell(master_clear) |-> csr_rdata == 16'h0000 && !rx_irq)
      else $error("word not cleared");
   AST_DONE_P:
      assert property (cc_ovf_pri |=> csr_rdata[7])
      else $error("primary done not set");
   AST_DONE_S:
      assert property (cc_ovf_sec || seq_done_sec |=> csr_rdata[6])
      else $error("secondary done not set");
   AST_IRQ:
      assert property (!$past(master_clear) |-> rx_irq == $past((csr_rdata[15] && csr_rdata[4])
         || ((|csr_rdata[7:6]) && csr_rdata[5]))) else $error("request wrong");
   AST_FLAG:
      assert property ($rose(csr_rdata[15]) |-> $past(rx_char_stb && rx_enable && !total_transp))
      else $error("flag without accepted character");
   AST_ADDR_LOCK:
      assert property (csr_wr && csr_be[1] && (tx_active || csr_rdata[12]) && !rx_char_stb
         |=> $stable(csr_rdata[11:8])) else $error("address written while active");
   AST_ADDR_WR:
      assert property (csr_wr && csr_be[1] && !tx_active && !csr_rdata[12] && !rx_char_stb
         |=> csr_rdata[11:8] == $past(csr_wdata[11:8])) else $error("address not written");
   AST_BUF_HOLD:
      assert property (!cc_ovf_pri && !cc_ovf_sec |=> $stable(csr_rdata[2]))
      else $error("buffer set moved");
endmodule // srsc_rx_csr_sva
bind srsc_rx_csr srsc_rx_csr_sva srsc_rx_csr_sva_inst (.mclk, .sys_rst, .master_clear,
   .csr_wr, .csr_be, .csr_wdata, .csr_rdata, .total_transp, .rx_go, .tx_active, .cc_ovf_pri,
   .cc_ovf_sec, .seq_done_sec, .rx_char_stb, .rx_enable, .rx_irq);
`default_nettype wire

// ===== dv/srsc_host_model.sv
// host software model: status word writes and indirect pattern access
`timescale 1ns/1ps
`default_nettype none
module srsc_host_model (
   input  wire logic        mclk,       // interface clock
   output var  logic        csr_wr,     // status write strobe
   output var  logic [1:0]  csr_be,     // byte enables
   output var  logic [15:0] csr_wdata,  // status write data
   output var  logic [3:0]  regerr_ptr, // register/error pointer
   output var  logic        win_wr,     // window write strobe
   output var  logic [15:0] win_wdata   // window write data
);
   initial
   begin
      {csr_wr, csr_be, csr_wdata} = 19'h0;
      {regerr_ptr, win_wr, win_wdata} = 21'h0;
   end
   task automatic csr_write(input logic [1:0] be, input logic [15:0] d);
   begin
      @(posedge mclk) {csr_wr, csr_be, csr_wdata} <= {1'b1, be, d};
      @(posedge mclk) csr_wr <= 1'b0;
      #1;
   end
   endtask
   // only called while link idle, else the address write is lost
   task automatic pat_write(input logic [3:0] a, input logic [15:0] d);
   begin
      @(posedge mclk) regerr_ptr <= 4'h8;
      csr_write(2'b10, {4'h0, a, 8'h00});
      @(posedge mclk) {win_wr, win_wdata} <= {1'b1, d};
      @(posedge mclk) win_wr <= 1'b0;
   end
   endtask
endmodule // srsc_host_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the receive control and status word
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 1'b0, sys_rst = 1'b1, master_clear = 1'b0, total_transp = 1'b0;
   logic rx_go = 1'b0, rx_term = 1'b0, tx_active = 1'b0, cc_ovf_pri = 1'b0, cc_ovf_sec = 1'b0;
   logic seq_done_pri = 1'b0, seq_done_sec = 1'b0, rx_char_stb = 1'b0, rx_char_wide = 1'b0;
   logic rx_double = 1'b0, sync_det = 1'b0, sync_flag_en = 1'b0, sync_lost = 1'b0;
   logic [15:0] rx_char = 16'h0000;
   logic [15:0] csr_rdata, win_rdata, csr_wdata, win_wdata;
   logic [3:0] regerr_ptr;
   logic [1:0] csr_be;
   logic csr_wr, win_wr, rx_enable, mem_xfer_stb, rx_irq;
   int err_count = 0;
   int tests_run = 0;
   always #25 mclk = ~mclk;
   srsc_host_model srsc_host_model_inst (.mclk, .csr_wr, .csr_be, .csr_wdata, .regerr_ptr,
      .win_wr, .win_wdata);
   srsc_rx_csr srsc_rx_csr_inst (.mclk, .sys_rst, .master_clear, .csr_wr, .csr_be, .csr_wdata,
      .csr_rdata, .regerr_ptr, .total_transp, .win_wr, .win_wdata, .win_rdata, .rx_go, .rx_term,
      .tx_active, .cc_ovf_pri, .cc_ovf_sec, .seq_done_pri, .seq_done_sec, .rx_char_stb,
      .rx_char, .rx_char_wide, .rx_double, .sync_det, .sync_flag_en, .sync_lost, .rx_enable,
      .mem_xfer_stb, .rx_irq);
///////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
   begin
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task automatic tk(input int n);
   begin
      repeat (n) @(posedge mclk);
      #1;
   end
   endtask
   task automatic chr(input logic [15:0] c, input logic w, input logic dbl, input logic sy);
   begin
      @(posedge mclk) {rx_char_stb, rx_char, rx_char_wide} <= {1'b1, c, w};
      {rx_double, sync_det} <= {dbl, sy};
      @(posedge mclk) {rx_char_stb, sync_det} <= 2'b00;
      #1;
   end
   endtask
   task automatic t_rw;
   begin
      srsc_host_model_inst.csr_write(2'b11, 16'hffff);
      chk("word", csr_rdata, 16'h0ff8);
      tk(1);
      chk("irq", {15'h0, rx_irq}, 16'h0001);
      @(posedge mclk) rx_go <= 1'b1;
      tk(0);
      chk("rxen", {15'h0, rx_enable}, 16'h0001);
      @(posedge mclk) tx_active <= 1'b1;
      tk(0);
      chk("rxen hd", {15'h0, rx_enable}, 16'h0000);
      @(posedge mclk) tx_active <= 1'b0;
      srsc_host_model_inst.csr_write(2'b01, 16'h0000);
      tk(2);
      chk("irq off", {15'h0, rx_irq}, 16'h0000);
      @(posedge mclk) master_clear <= 1'b1;
      @(posedge mclk) master_clear <= 1'b0;
      tk(0);
      chk("clear", csr_rdata, 16'h0000);
      $display("test rw done");
   end
   endtask
   task automatic t_match;
   begin
      for (int i = 0; i < 16; i++)
         srsc_host_model_inst.pat_write(i[3:0], {4'h6, i[3:0], 8'h00});
      srsc_host_model_inst.csr_write(2'b10, 16'h0500);
      tk(2);
      chk("window", win_rdata, 16'h6500);
      srsc_host_model_inst.csr_write(2'b11, 16'h0010);
      chr(16'h0063, 1'b0, 1'b0, 1'b0);
      chk("narrow", csr_rdata, 16'h8310);
      chk("xfer", {15'h0, mem_xfer_stb}, 16'h0001);
      tk(1);
      chk("char irq", {15'h0, rx_irq}, 16'h0001);
      chr(16'h6a00, 1'b1, 1'b1, 1'b0);
      chk("wide", csr_rdata, 16'h8a10);
      chk("xfer dbl", {15'h0, mem_xfer_stb}, 16'h0000);
      srsc_host_model_inst.csr_write(2'b10, 16'h0000);
      @(posedge mclk) total_transp <= 1'b1;
      chr(16'h0063, 1'b0, 1'b0, 1'b0);
      chk("transp", csr_rdata, 16'h0010);
      chk("xfer held", {15'h0, mem_xfer_stb}, 16'h0001);
      @(posedge mclk) total_transp <= 1'b0;
      $display("test match done");
   end
   endtask
   task automatic t_done;
   begin
      srsc_host_model_inst.csr_write(2'b01, 16'h0020);
      @(posedge mclk) cc_ovf_pri <= 1'b1;
      @(posedge mclk) cc_ovf_pri <= 1'b0;
      tk(0);
      chk("pri", csr_rdata, 16'h00a4);
      @(posedge mclk) rx_term <= 1'b1;
      @(posedge mclk) rx_term <= 1'b0;
      tk(1);
      chk("term", csr_rdata, 16'h00a4);
      @(posedge mclk) cc_ovf_sec <= 1'b1;
      @(posedge mclk) cc_ovf_sec <= 1'b0;
      tk(1);
      chk("sec", csr_rdata, 16'h00e0);
      chk("done irq", {15'h0, rx_irq}, 16'h0001);
      srsc_host_model_inst.csr_write(2'b01, 16'h0000);
      chk("sw clear", csr_rdata, 16'h0000);
      @(posedge mclk) {seq_done_pri, seq_done_sec} <= 2'b11;
      @(posedge mclk) {seq_done_pri, seq_done_sec} <= 2'b00;
      tk(0);
      chk("seq", csr_rdata, 16'h00c0);
      $display("test done flags done");
   end
   endtask
   task automatic t_sync;
   begin
      @(posedge mclk) master_clear <= 1'b1;
      @(posedge mclk) {master_clear, sync_flag_en} <= 2'b01;
      chr(16'h0016, 1'b0, 1'b0, 1'b1);
      chk("sync one", csr_rdata, 16'h8800);
      chr(16'h0016, 1'b0, 1'b0, 1'b1);
      tk(2);
      chk("active", csr_rdata, 16'h9800);
      srsc_host_model_inst.csr_write(2'b10, 16'h0300);
      chk("locked", csr_rdata, 16'h1800);
      @(posedge mclk) sync_lost <= 1'b1;
      @(posedge mclk) sync_lost <= 1'b0;
      tk(0);
      chk("resync", csr_rdata, 16'h0800);
      $display("test sync done");
   end
   endtask
   task automatic close_out;
   begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (5000) @(posedge mclk);
      err_count++;
      close_out;
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      tk(1);
      chk("reset", csr_rdata, 16'h0000);
      t_rw;
      t_match;
      t_done;
      t_sync;
      close_out;
   end
endmodule // tb
`default_nettype wire
